// ===== design/mtpc_top.sv
// Functional notes
// - Setup only when servo off; then power cycle
// - Alarm reset never clears backup/checksum alarms
// - Maximum limit: signed 16-bit multi-turn count
// - Other limit: count stays zero to limit
// - Negative turn from zero loads limit
// - Positive turn from limit loads zero
// - Wrap only while absolute mode selected
// - Limit and mode adopted at power-up only
// - Encoder limit defaults to maximum value
// - Power-up limit difference raises mismatch alarm
// - Mismatch alarm lines: on, off, on
// - Rewrite only during mismatch; then power cycle
// - Rewrite copies limit, clears alarm, unchecked
// - Encoder monitoring alarm released by power-off
// - Fieldbus write during local session times out
// - Indicators dark while parameter unit attached
// - Indicators dark three seconds after power-up
// - Indicators dark during trace, briefly on access
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module mtpc_top #(
	parameter int STARTUP_BLANK_CYCLES = mtpc_pkg::STARTUP_BLANK_CYCLES,
	parameter int BRIEF_BLANK_CYCLES   = mtpc_pkg::BRIEF_BLANK_CYCLES
) (
	input  wire logic        SYS_CLK,
	input  wire logic        NRST,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             IRQ,
	input  wire logic        SERVO_ON,
	input  wire logic [15:0] NV_MULTITURN_LIMIT_PARAM,
	input  wire logic        NV_ABSOLUTE_MODE_SELECT,
	input  wire logic [15:0] ENC_STORED_LIMIT,
	input  wire logic        ENC_TURN_POS,
	input  wire logic        ENC_TURN_NEG,
	input  wire logic        ENC_BACKUP_ERR,
	input  wire logic        ENC_CHECKSUM_ERR,
	input  wire logic        ENC_MONITOR_ALARM,
	output logic             ENC_LIMIT_WRITE,
	output logic      [15:0] ENC_LIMIT_DATA,
	output logic      [15:0] MULTITURN_COUNT,
	input  wire logic        PANEL_UNIT_ATTACHED,
	input  wire logic        PC_SESSION_ACTIVE,
	input  wire logic        FB_PARAM_WRITE,
	input  wire logic        FB_PARAM_READ,
	input  wire logic        FB_TRACE_ACTIVE,
	output logic             FB_TIMEOUT,
	output logic             PANEL_LEDS_ON,
	output logic             ALARM_CODE_LINE_ONE,
	output logic             ALARM_CODE_LINE_TWO,
	output logic             ALARM_CODE_LINE_THREE
);

	initial begin
		if (STARTUP_BLANK_CYCLES < 1 || BRIEF_BLANK_CYCLES < 1) begin
			$error("mtpc_top: blanking counts must be at least one cycle");
		end
	end

	// Bus handshake
	logic        bus_ack;
	logic        bus_req;
	logic        wr_fire;
	logic [31:0] lane_mask;
	logic [31:0] wdata_m;

	// Power-up captured settings
	logic        powered;
	logic [15:0] limit_param;
	logic        abs_mode_sel;
	logic [15:0] enc_limit;

	// Alarms and lockout
	logic mismatch_alarm;
	logic backup_alarm;
	logic checksum_alarm;
	logic monitor_alarm;
	logic need_power_cycle;

	// Commands
	logic setup_req;
	logic rewrite_req;
	logic setup_ok;
	logic rewrite_ok;
	logic cmd_refused;

	// Interrupts
	logic [mtpc_pkg::IRQ_W-1:0] irq_status;
	logic [mtpc_pkg::IRQ_W-1:0] irq_enable;
	logic [mtpc_pkg::IRQ_W-1:0] irq_events;
	logic [mtpc_pkg::IRQ_W-1:0] irq_clear;
	logic                       mismatch_event;
	logic                       enc_alarm_event;
	logic                       fb_timeout_event;

	// Indicator blanking
	logic [31:0] startup_timer;
	logic [31:0] brief_timer;

	logic [31:0] next_readdata;

	mtpc_turn_if turn ();

	// Avalon slave: one wait cycle, answer at the second edge
	assign bus_req         = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = bus_req & ~bus_ack;
	assign wr_fire         = AVS_WRITE & bus_ack;

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// Byte lanes gate the write data
	always_comb begin
		lane_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
			{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
		wdata_m = AVS_WRITEDATA & lane_mask;
	end

	// Settings are latched once after reset release, later pin changes wait
	// for the next power cycle
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			powered      <= 1'b0;
			limit_param  <= mtpc_pkg::LIMIT_MAX;
			abs_mode_sel <= mtpc_pkg::ABS_MODE_ABSOLUTE;
		end else if (!powered) begin
			powered      <= 1'b1;
			limit_param  <= NV_MULTITURN_LIMIT_PARAM;
			abs_mode_sel <= NV_ABSOLUTE_MODE_SELECT;
		end
	end

	// Encoder-side limit copy; starts at the maximum like the driver default
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			enc_limit <= mtpc_pkg::LIMIT_MAX;
		end else if (!powered) begin
			enc_limit <= ENC_STORED_LIMIT;
		end else if (rewrite_ok) begin
			enc_limit <= limit_param;
		end
	end

	// Command decode from the command register
	always_comb begin
		setup_req   = wr_fire && (AVS_ADDRESS == mtpc_pkg::REG_COMMAND) &&
			wdata_m[mtpc_pkg::CMD_SETUP];
		rewrite_req = wr_fire && (AVS_ADDRESS == mtpc_pkg::REG_COMMAND) &&
			wdata_m[mtpc_pkg::CMD_REWRITE];
		setup_ok    = setup_req && !SERVO_ON && !need_power_cycle;
		rewrite_ok  = rewrite_req && mismatch_alarm && !need_power_cycle;
		cmd_refused = (setup_req && !setup_ok) || (rewrite_req && !rewrite_ok);
	end

	// After setup or rewrite no further setup or rewrite command is accepted until reset
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			need_power_cycle <= 1'b0;
		end else if (setup_ok || rewrite_ok) begin
			need_power_cycle <= 1'b1;
		end
	end

	// Mismatch alarm: raised by the power-up compare, cleared only by rewrite,
	// which trusts the driver value as it stands
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			mismatch_alarm <= 1'b0;
		end else if (!powered) begin
			mismatch_alarm <= (NV_MULTITURN_LIMIT_PARAM != ENC_STORED_LIMIT);
		end else if (rewrite_ok) begin
			mismatch_alarm <= 1'b0;
		end
	end

	assign mismatch_event = !powered && (NV_MULTITURN_LIMIT_PARAM != ENC_STORED_LIMIT);

	// Backup and checksum alarms clear only through setup; a still-present
	// error keeps its alarm set because the set wins
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			backup_alarm   <= 1'b0;
			checksum_alarm <= 1'b0;
		end else begin
			if (ENC_BACKUP_ERR) begin
				backup_alarm <= 1'b1;
			end else if (setup_ok) begin
				backup_alarm <= 1'b0;
			end
			if (ENC_CHECKSUM_ERR) begin
				checksum_alarm <= 1'b1;
			end else if (setup_ok) begin
				checksum_alarm <= 1'b0;
			end
		end
	end

	// Monitoring alarm has no clear path at all but reset
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			monitor_alarm <= 1'b0;
		end else if (ENC_MONITOR_ALARM) begin
			monitor_alarm <= 1'b1;
		end
	end

	assign enc_alarm_event = (ENC_BACKUP_ERR && !backup_alarm) ||
		(ENC_CHECKSUM_ERR && !checksum_alarm) ||
		(ENC_MONITOR_ALARM && !monitor_alarm);

	// Alarm code lines, active low
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			{ALARM_CODE_LINE_ONE, ALARM_CODE_LINE_TWO, ALARM_CODE_LINE_THREE} <=
				mtpc_pkg::ALARM_LEVELS_IDLE;
		end else if (mismatch_alarm) begin
			{ALARM_CODE_LINE_ONE, ALARM_CODE_LINE_TWO, ALARM_CODE_LINE_THREE} <=
				mtpc_pkg::ALARM_LEVELS_MISMATCH;
		end else begin
			{ALARM_CODE_LINE_ONE, ALARM_CODE_LINE_TWO, ALARM_CODE_LINE_THREE} <=
				mtpc_pkg::ALARM_LEVELS_IDLE;
		end
	end

	// Encoder limit write strobe carries the driver value unchecked
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			ENC_LIMIT_WRITE <= 1'b0;
			ENC_LIMIT_DATA  <= mtpc_pkg::LIMIT_MAX;
		end else begin
			ENC_LIMIT_WRITE <= rewrite_ok;
			if (rewrite_ok) begin
				ENC_LIMIT_DATA <= limit_param;
			end
		end
	end

	// Multi-turn counter; frozen until settings are captured
	assign turn.step_up   = powered && ENC_TURN_POS;
	assign turn.step_down = powered && ENC_TURN_NEG;
	assign turn.clear     = setup_ok;
	assign turn.limit     = limit_param;
	assign turn.wrap_en   = (abs_mode_sel == mtpc_pkg::ABS_MODE_ABSOLUTE) &&
		(limit_param != mtpc_pkg::LIMIT_MAX);

	mtpc_turn_counter #(
		.CNT_W (mtpc_pkg::LIMIT_W)
	) u_counter (
		.clk   (SYS_CLK),
		.rst_n (NRST),
		.turn  (turn)
	);

	assign MULTITURN_COUNT = turn.count;

	// Fieldbus write collides with a local session and is timed out
	assign fb_timeout_event = FB_PARAM_WRITE && (PANEL_UNIT_ATTACHED || PC_SESSION_ACTIVE);

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			FB_TIMEOUT <= 1'b0;
		end else begin
			FB_TIMEOUT <= fb_timeout_event;
		end
	end

	// Startup dark period counts down once from reset
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			startup_timer <= 32'(STARTUP_BLANK_CYCLES);
		end else if (startup_timer != 32'h00000000) begin
			startup_timer <= startup_timer - 32'h00000001;
		end
	end

	// Brief blink restarts on every parameter access
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			brief_timer <= 32'h00000000;
		end else if (FB_PARAM_READ || FB_PARAM_WRITE) begin
			brief_timer <= 32'(BRIEF_BLANK_CYCLES);
		end else if (brief_timer != 32'h00000000) begin
			brief_timer <= brief_timer - 32'h00000001;
		end
	end

	// Indicator enable, registered so the panel sees no glitches
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			PANEL_LEDS_ON <= 1'b0;
		end else begin
			PANEL_LEDS_ON <= !PANEL_UNIT_ATTACHED &&
				(startup_timer == 32'h00000000) &&
				!FB_TRACE_ACTIVE &&
				(brief_timer == 32'h00000000) &&
				!(FB_PARAM_READ || FB_PARAM_WRITE);
		end
	end

	// Interrupt events and software clear
	always_comb begin
		irq_events = '0;
		irq_events[mtpc_pkg::EV_MISMATCH]     = mismatch_event;
		irq_events[mtpc_pkg::EV_SETUP_DONE]   = setup_ok;
		irq_events[mtpc_pkg::EV_REWRITE_DONE] = rewrite_ok;
		irq_events[mtpc_pkg::EV_REFUSED]      = cmd_refused;
		irq_events[mtpc_pkg::EV_FB_TIMEOUT]   = fb_timeout_event;
		irq_events[mtpc_pkg::EV_ENC_ALARM]    = enc_alarm_event;
		irq_clear = '0;
		if (wr_fire && (AVS_ADDRESS == mtpc_pkg::REG_IRQ_CLEAR)) begin
			irq_clear = wdata_m[mtpc_pkg::IRQ_W-1:0];
		end
	end

	// Sticky status; an event in the clear cycle survives
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			irq_enable <= mtpc_pkg::IRQ_ENABLE_RESET;
		end else if (wr_fire && (AVS_ADDRESS == mtpc_pkg::REG_IRQ_ENABLE)) begin
			irq_enable <= (irq_enable & ~lane_mask[mtpc_pkg::IRQ_W-1:0]) |
				wdata_m[mtpc_pkg::IRQ_W-1:0];
		end
	end

	assign IRQ = |(irq_status & irq_enable);

	// Read mux; write-only and unmapped words read as zero
	always_comb begin
		next_readdata = 32'h00000000;
		unique case (AVS_ADDRESS)
			mtpc_pkg::REG_STATUS: begin
				next_readdata[mtpc_pkg::ST_MISMATCH]   = mismatch_alarm;
				next_readdata[mtpc_pkg::ST_BACKUP]     = backup_alarm;
				next_readdata[mtpc_pkg::ST_CHECKSUM]   = checksum_alarm;
				next_readdata[mtpc_pkg::ST_MONITOR]    = monitor_alarm;
				next_readdata[mtpc_pkg::ST_NEED_CYCLE] = need_power_cycle;
				next_readdata[mtpc_pkg::ST_LEDS_ON]    = PANEL_LEDS_ON;
				next_readdata[mtpc_pkg::ST_WRAP_MODE]  = turn.wrap_en;
				next_readdata[mtpc_pkg::ST_SERVO_ON]   = SERVO_ON;
			end
			mtpc_pkg::REG_COUNT: begin
				next_readdata = {{16{turn.count[15]}}, turn.count};
			end
			mtpc_pkg::REG_LIMITS: begin
				next_readdata = {enc_limit, limit_param};
			end
			mtpc_pkg::REG_IRQ_STATUS: begin
				next_readdata[mtpc_pkg::IRQ_W-1:0] = irq_status;
			end
			mtpc_pkg::REG_IRQ_ENABLE: begin
				next_readdata[mtpc_pkg::IRQ_W-1:0] = irq_enable;
			end
			default: begin
				next_readdata = 32'h00000000;
			end
		endcase
	end

	// Read data is loaded in the wait cycle so it stands at the answer edge
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			AVS_READDATA <= 32'h00000000;
		end else if (AVS_READ && !bus_ack) begin
			AVS_READDATA <= next_readdata;
		end
	end

endmodule

`default_nettype wire

// ===== design/mtpc_pkg.sv
package mtpc_pkg;

	// Clock rate and timing
	localparam int CLK_KHZ          = 100000;
	localparam int STARTUP_BLANK_MS = 3000;
	localparam int BRIEF_BLANK_MS   = 20;
	localparam int STARTUP_BLANK_CYCLES = STARTUP_BLANK_MS * CLK_KHZ;
	localparam int BRIEF_BLANK_CYCLES   = BRIEF_BLANK_MS * CLK_KHZ;

	// Multi-turn limit
	localparam int          LIMIT_W   = 16;
	localparam logic [15:0] LIMIT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	// Absolute mode select value that enables absolute operation
	localparam logic ABS_MODE_ABSOLUTE = 1'b0;

	// Register byte offsets
	localparam logic [5:0] REG_STATUS     = 6'h00;
	localparam logic [5:0] REG_COUNT      = 6'h04;
	localparam logic [5:0] REG_LIMITS     = 6'h08;
	localparam logic [5:0] REG_COMMAND    = 6'h0c;
	localparam logic [5:0] REG_IRQ_STATUS = 6'h10;
	localparam logic [5:0] REG_IRQ_CLEAR  = 6'h14;
	localparam logic [5:0] REG_IRQ_ENABLE = 6'h18;

	// Status register fields
	localparam int ST_MISMATCH   = 0;
	localparam int ST_BACKUP     = 1;
	localparam int ST_CHECKSUM   = 2;
	localparam int ST_MONITOR    = 3;
	localparam int ST_NEED_CYCLE = 4;
	localparam int ST_LEDS_ON    = 5;
	localparam int ST_WRAP_MODE  = 6;
	localparam int ST_SERVO_ON   = 7;

	// Command register fields
	localparam int CMD_SETUP   = 0;
	localparam int CMD_REWRITE = 1;

	// Interrupt event fields
	localparam int IRQ_W           = 6;
	localparam int EV_MISMATCH     = 0;
	localparam int EV_SETUP_DONE   = 1;
	localparam int EV_REWRITE_DONE = 2;
	localparam int EV_REFUSED      = 3;
	localparam int EV_FB_TIMEOUT   = 4;
	localparam int EV_ENC_ALARM    = 5;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 6'h00;

	// Alarm code line levels, line one in the top bit; on is low
	localparam logic [2:0] ALARM_LEVELS_IDLE     = 3'h7;
	localparam logic [2:0] ALARM_LEVELS_MISMATCH = 3'h2;

endpackage

// ===== design/mtpc_turn_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mtpc_turn_if;
	logic        step_up;
	logic        step_down;
	logic        clear;
	logic        wrap_en;
	logic [15:0] limit;
	logic [15:0] count;

	modport ctrl (output step_up, output step_down, output clear, output wrap_en,
		output limit, input count);
	modport cnt (input step_up, input step_down, input clear, input wrap_en,
		input limit, output count);
endinterface

`default_nettype wire

// ===== design/mtpc_turn_counter.sv
`timescale 1ns/1ps
`default_nettype none

module mtpc_turn_counter #(
	parameter int CNT_W = 16
) (
	input  wire logic   clk,
	input  wire logic   rst_n,
	mtpc_turn_if.cnt    turn
);

	initial begin
		if (CNT_W != mtpc_pkg::LIMIT_W) begin
			$error("mtpc_turn_counter: CNT_W must equal the limit width");
		end
	end

	logic [CNT_W-1:0] next_count;

	// Next count; a stray double step counts nothing rather than guessing
	always_comb begin
		next_count = turn.count;
		if (turn.clear) begin
			next_count = mtpc_pkg::COUNT_ZERO;
		end else if (turn.step_up && !turn.step_down) begin
			if (turn.wrap_en && (turn.count == turn.limit)) begin
				next_count = mtpc_pkg::COUNT_ZERO;
			end else if (turn.wrap_en && (turn.count > turn.limit)) begin
				next_count = mtpc_pkg::COUNT_ZERO;
			end else begin
				next_count = turn.count + 16'h0001;
			end
		end else if (turn.step_down && !turn.step_up) begin
			if (turn.wrap_en && (turn.count == mtpc_pkg::COUNT_ZERO)) begin
				next_count = turn.limit;
			end else if (turn.wrap_en && (turn.count > turn.limit)) begin
				next_count = turn.limit;
			end else begin
				next_count = turn.count - 16'h0001;
			end
		end
	end

	// Count register; full range wraps -32768..+32767 as two's complement
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			turn.count <= mtpc_pkg::COUNT_ZERO;
		end else begin
			turn.count <= next_count;
		end
	end

endmodule

`default_nettype wire

// ===== verification/mtpc_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none

module mtpc_encoder_model (
	input  wire logic        clk,
	input  wire logic        spin_pos,
	input  wire logic        spin_neg,
	input  wire logic        limit_write,
	input  wire logic [15:0] limit_data,
	output logic      [15:0] stored_limit,
	output logic             turn_pos,
	output logic             turn_neg
);
	logic [2:0] angle;

	// Encoder memory survives driver power cycles, so nothing here sees the reset
	initial begin
		stored_limit = 16'hffff;
		angle = 3'h0;
		turn_pos = 1'b0;
		turn_neg = 1'b0;
	end

	// Eight angle steps per turn; one pulse as the angle crosses zero
	always @(posedge clk) begin
		if (limit_write) stored_limit <= limit_data;
		turn_pos <= spin_pos && angle == 3'h7;
		turn_neg <= spin_neg && angle == 3'h0;
		if (spin_pos) angle <= angle + 3'h1;
		else if (spin_neg) angle <= angle - 3'h1;
	end
endmodule

`default_nettype wire

// ===== verification/mtpc_properties.sv
`timescale 1ns/1ps
`default_nettype none

module mtpc_properties #(
	parameter int STARTUP_BLANK_CYCLES = 20
) (
	input wire logic        SYS_CLK,
	input wire logic        NRST,
	input wire logic [15:0] NV_MULTITURN_LIMIT_PARAM,
	input wire logic        NV_ABSOLUTE_MODE_SELECT,
	input wire logic [15:0] ENC_STORED_LIMIT,
	input wire logic        ENC_TURN_POS,
	input wire logic        ENC_TURN_NEG,
	input wire logic        ENC_LIMIT_WRITE,
	input wire logic [15:0] ENC_LIMIT_DATA,
	input wire logic [15:0] MULTITURN_COUNT,
	input wire logic        PANEL_UNIT_ATTACHED,
	input wire logic        PC_SESSION_ACTIVE,
	input wire logic        FB_PARAM_WRITE,
	input wire logic        FB_PARAM_READ,
	input wire logic        FB_TIMEOUT,
	input wire logic        PANEL_LEDS_ON,
	input wire logic        ALARM_CODE_LINE_ONE,
	input wire logic        ALARM_CODE_LINE_TWO,
	input wire logic        ALARM_CODE_LINE_THREE
);
	logic [7:0]  c;
	logic [15:0] lim_q;
	logic [15:0] enc_q;
	logic        mode_q;
	logic        run;
	logic        wrap;
	logic [2:0]  lines;

	// Edges since release, saturating
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) c <= 8'h00;
		else if (c != 8'hff) c <= c + 8'h01;
	end

	// Settings as adopted at the first edge; later pin changes must not matter
	always_ff @(posedge SYS_CLK) begin
		if (c == 8'h00) begin
			lim_q <= NV_MULTITURN_LIMIT_PARAM;
			enc_q <= ENC_STORED_LIMIT;
			mode_q <= NV_ABSOLUTE_MODE_SELECT;
		end
	end

	// Turn pulses are ignored at the capture edge
	assign run = c != 8'h00;
	assign wrap = mode_q == mtpc_pkg::ABS_MODE_ABSOLUTE && lim_q != mtpc_pkg::LIMIT_MAX;
	assign lines = {ALARM_CODE_LINE_ONE, ALARM_CODE_LINE_TWO, ALARM_CODE_LINE_THREE};

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	sequence s_dark2;
		!PANEL_LEDS_ON [*2];
	endsequence
	sequence s_idle_lines;
		lines == mtpc_pkg::ALARM_LEVELS_IDLE;
	endsequence

	a_count_free: assert property (run && !wrap && ENC_TURN_POS && !ENC_TURN_NEG |=>
		MULTITURN_COUNT == $past(MULTITURN_COUNT) + 16'h0001) else $error("free count step");
	a_wrap_top: assert property (run && wrap && ENC_TURN_POS && !ENC_TURN_NEG &&
		MULTITURN_COUNT == lim_q |=> MULTITURN_COUNT == 16'h0000) else $error("top wrap");
	a_wrap_zero: assert property (run && wrap && ENC_TURN_NEG && !ENC_TURN_POS &&
		MULTITURN_COUNT == 16'h0000 |=> MULTITURN_COUNT == lim_q) else $error("zero wrap");
	a_range_keep: assert property (run && wrap |-> MULTITURN_COUNT <= lim_q)
		else $error("count out of range");
	a_mismatch_lines: assert property (c == 8'h02 |-> lines == (lim_q != enc_q ?
		mtpc_pkg::ALARM_LEVELS_MISMATCH : mtpc_pkg::ALARM_LEVELS_IDLE)) else $error("alarm lines");
	a_rewrite_gate: assert property (ENC_LIMIT_WRITE |->
		lines == mtpc_pkg::ALARM_LEVELS_MISMATCH && ENC_LIMIT_DATA == lim_q) else $error("rewrite");
	a_rewrite_clear: assert property (ENC_LIMIT_WRITE |=> s_idle_lines)
		else $error("alarm kept after rewrite");
	a_fb_timeout: assert property (run && FB_PARAM_WRITE &&
		(PANEL_UNIT_ATTACHED || PC_SESSION_ACTIVE) |=> FB_TIMEOUT) else $error("no timeout");
	a_panel_dark: assert property (PANEL_UNIT_ATTACHED |=> !PANEL_LEDS_ON)
		else $error("lit with unit attached");
	a_startup_dark: assert property (int'(c) <= STARTUP_BLANK_CYCLES |-> !PANEL_LEDS_ON)
		else $error("lit during start");
	a_access_dark: assert property (run && (FB_PARAM_READ || FB_PARAM_WRITE) |=> s_dark2)
		else $error("lit during access");
endmodule

bind mtpc_top mtpc_properties #(.STARTUP_BLANK_CYCLES(STARTUP_BLANK_CYCLES))
	mtpc_properties_inst (.*);

`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	typedef struct packed {
		logic [15:0] lim;
		logic        md;
		logic        dir;
		logic [3:0]  turns;
		logic [15:0] exp;
	} mtpc_row_type;

	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        servo_on = 1'b0;
	logic [15:0] nv_limit = 16'hffff;
	logic        nv_mode = 1'b0;
	logic [15:0] enc_limit;
	logic [15:0] enc_wdata;
	logic        enc_write;
	logic        turn_pos;
	logic        turn_neg;
	logic        spin_pos = 1'b0;
	logic        spin_neg = 1'b0;
	logic        bad_mem = 1'b0;
	logic        mon_alarm = 1'b0;
	logic [15:0] count;
	logic        panel = 1'b0;
	logic        pc = 1'b0;
	logic        fb_write = 1'b0;
	logic        fb_read = 1'b0;
	logic        trace = 1'b0;
	logic        fb_timeout;
	logic        leds;
	logic [2:0]  lines;
	logic [15:0] cur_lim = 16'hffff;
	logic        cur_md = 1'b0;
	logic [31:0] q;
	logic        seen;
	int          errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	mtpc_row_type rows [7] = '{'{16'hffff, 1'b0, 1'b0, 4'h1, 16'hffff},
		'{16'hffff, 1'b0, 1'b0, 4'h1, 16'hfffe}, '{16'hffff, 1'b0, 1'b1, 4'h3, 16'h0001},
		'{16'h0003, 1'b0, 1'b1, 4'h3, 16'h0003}, '{16'h0003, 1'b0, 1'b1, 4'h1, 16'h0000},
		'{16'h0003, 1'b0, 1'b0, 4'h1, 16'h0003}, '{16'h0003, 1'b1, 1'b0, 4'h1, 16'hffff}};

	// Short blanking counts keep the run brief
	mtpc_top #(.STARTUP_BLANK_CYCLES(20), .BRIEF_BLANK_CYCLES(5)) mtpc_top_inst (
		.SYS_CLK(sys_clk), .NRST(nrst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
		.AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq),
		.SERVO_ON(servo_on), .NV_MULTITURN_LIMIT_PARAM(nv_limit), .NV_ABSOLUTE_MODE_SELECT(nv_mode),
		.ENC_STORED_LIMIT(enc_limit), .ENC_TURN_POS(turn_pos), .ENC_TURN_NEG(turn_neg),
		.ENC_BACKUP_ERR(bad_mem), .ENC_CHECKSUM_ERR(bad_mem), .ENC_MONITOR_ALARM(mon_alarm),
		.ENC_LIMIT_WRITE(enc_write), .ENC_LIMIT_DATA(enc_wdata), .MULTITURN_COUNT(count),
		.PANEL_UNIT_ATTACHED(panel), .PC_SESSION_ACTIVE(pc), .FB_PARAM_WRITE(fb_write),
		.FB_PARAM_READ(fb_read), .FB_TRACE_ACTIVE(trace), .FB_TIMEOUT(fb_timeout),
		.PANEL_LEDS_ON(leds), .ALARM_CODE_LINE_ONE(lines[2]), .ALARM_CODE_LINE_TWO(lines[1]),
		.ALARM_CODE_LINE_THREE(lines[0]));
	mtpc_encoder_model mtpc_encoder_model_inst (.clk(sys_clk), .spin_pos(spin_pos),
		.spin_neg(spin_neg), .limit_write(enc_write), .limit_data(enc_wdata),
		.stored_limit(enc_limit), .turn_pos(turn_pos), .turn_neg(turn_neg));

	// Clock and hang guard
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
		tests_run++;
		if (seen_v !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen_v);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Power cycle; settings change only while the driver is down
	task automatic power_up(input logic [15:0] lim, input logic md);
		nrst <= 1'b0;
		nv_limit <= lim;
		nv_mode <= md;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (25) @(posedge sys_clk);
	endtask

	task automatic configure(input logic [15:0] lim, input logic md);
		logic mis;
		mis = lim !== enc_limit;
		power_up(lim, md);
		chk("alarm lines", {29'h0, lines}, mis ? 32'h2 : 32'h7);
		if (mis) begin
			bus(1'b1, mtpc_pkg::REG_COMMAND, 32'h2);
			repeat (3) @(posedge sys_clk);
			chk("encoder limit", {16'h0, enc_limit}, {16'h0, lim});
			chk("lines after rewrite", {29'h0, lines}, 32'h7);
			power_up(lim, md);
		end
		cur_lim = lim;
		cur_md = md;
	endtask

	// Eight angle steps make one turn
	task automatic spin(input logic dir, input logic [3:0] turns);
		spin_pos <= dir;
		spin_neg <= !dir;
		repeat (8 * turns) @(posedge sys_clk);
		spin_pos <= 1'b0;
		spin_neg <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic fb_pulse(input logic wr);
		fb_write <= wr;
		fb_read <= !wr;
		@(posedge sys_clk);
		fb_write <= 1'b0;
		fb_read <= 1'b0;
		@(posedge sys_clk);
		seen = fb_timeout;
	endtask

	initial begin
		power_up(16'hffff, 1'b0);
		chk("leds", {31'h0, leds}, 32'h1);
		bus(1'b0, mtpc_pkg::REG_LIMITS, 32'h0);
		chk("limits", q, 32'hffffffff);
		for (int i = 0; i < 7; i++) begin
			if (rows[i].lim !== cur_lim || rows[i].md !== cur_md) configure(rows[i].lim, rows[i].md);
			spin(rows[i].dir, rows[i].turns);
			chk("count", {16'h0, count}, {16'h0, rows[i].exp});
			bus(1'b0, mtpc_pkg::REG_COUNT, 32'h0);
			chk("count reg", q, {{16{rows[i].exp[15]}}, rows[i].exp});
			$display("row %0d done", i);
		end
		// Setting pins change with no power cycle
		configure(16'h0003, 1'b0);
		nv_limit <= 16'h0005;
		nv_mode <= 1'b1;
		spin(1'b1, 4'h4);
		chk("count kept old limit", {16'h0, count}, 32'h0);
		$display("setting change test done");
		// Alarms, commands and interrupts
		bus(1'b1, mtpc_pkg::REG_IRQ_ENABLE, 32'h3f);
		bad_mem <= 1'b1;
		mon_alarm <= 1'b1;
		servo_on <= 1'b1;
		@(posedge sys_clk);
		bad_mem <= 1'b0;
		mon_alarm <= 1'b0;
		bus(1'b1, mtpc_pkg::REG_COMMAND, 32'h1);
		bus(1'b0, mtpc_pkg::REG_STATUS, 32'h0);
		chk("status servo on", q & 32'h1f, 32'h0e);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(1'b1, mtpc_pkg::REG_IRQ_CLEAR, 32'h3f);
		bus(1'b0, mtpc_pkg::REG_IRQ_STATUS, 32'h0);
		chk("irq status", q, 32'h0);
		bus(1'b1, mtpc_pkg::REG_IRQ_ENABLE, 32'h2);
		servo_on <= 1'b0;
		spin(1'b1, 4'h2);
		bus(1'b1, mtpc_pkg::REG_COMMAND, 32'h1);
		bus(1'b0, mtpc_pkg::REG_STATUS, 32'h0);
		chk("status setup", q & 32'h1f, 32'h18);
		chk("count setup", {16'h0, count}, 32'h0);
		chk("irq setup", {31'h0, irq}, 32'h1);
		bus(1'b1, mtpc_pkg::REG_IRQ_CLEAR, 32'h3f);
		bus(1'b1, mtpc_pkg::REG_COMMAND, 32'h3);
		bus(1'b0, mtpc_pkg::REG_IRQ_STATUS, 32'h0);
		chk("refusals", q, 32'h08);
		chk("masked irq", {31'h0, irq}, 32'h0);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", q, 32'h0);
		configure(16'h0003, 1'b0);
		bus(1'b0, mtpc_pkg::REG_STATUS, 32'h0);
		chk("status power cycle", q & 32'h1f, 32'h00);
		$display("alarm and command test done");
		// Fieldbus and indicators
		panel <= 1'b1;
		fb_pulse(1'b1);
		chk("timeout unit", {31'h0, seen}, 32'h1);
		chk("leds unit", {31'h0, leds}, 32'h0);
		panel <= 1'b0;
		pc <= 1'b1;
		fb_pulse(1'b1);
		chk("timeout pc", {31'h0, seen}, 32'h1);
		pc <= 1'b0;
		fb_pulse(1'b1);
		chk("timeout free", {31'h0, seen}, 32'h0);
		repeat (10) @(posedge sys_clk);
		chk("leds back", {31'h0, leds}, 32'h1);
		trace <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("leds trace", {31'h0, leds}, 32'h0);
		trace <= 1'b0;
		repeat (10) @(posedge sys_clk);
		fb_pulse(1'b0);
		chk("leds read", {31'h0, leds}, 32'h0);
		$display("fieldbus test done");
		print_verdict();
	end
endmodule

`default_nettype wire
